/* rtl/ir_timer_pkg.sv */
// constants for the pwm timer pair with infrared carrier gating
package ir_timer_pkg;
    // ----------------------------------------------------------------
    // bus and widths
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          MAIN_W      = 16;
    localparam int          COMP_W      = 8;
    localparam int          CHANNELS    = 5;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_PRESC   = 8'h04;
    localparam logic [7:0]  OFS_PERIOD  = 8'h08;
    localparam logic [7:0]  OFS_COUNT   = 8'h0c;
    localparam logic [7:0]  OFS_CHMODE  = 8'h10;
    localparam logic [7:0]  OFS_CMP0    = 8'h14;
    localparam logic [7:0]  OFS_CMP4    = 8'h24;
    localparam logic [7:0]  OFS_C_CTRL  = 8'h28;
    localparam logic [7:0]  OFS_C_PER   = 8'h2c;
    localparam logic [7:0]  OFS_C_CMP   = 8'h30;
    localparam logic [7:0]  OFS_C_COUNT = 8'h34;
    localparam logic [7:0]  OFS_STATUS  = 8'h38;
    localparam logic [7:0]  OFS_MASK    = 8'h3c;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int          CTRL_RUN    = 0;
    localparam int          CTRL_MODE_L = 1;
    localparam int          CTRL_IR     = 3;
    localparam int          CCTRL_RUN   = 0;
    localparam int          ST_WRAP     = 5;
    localparam int          ST_C_WRAP   = 6;
    localparam int          ST_W        = 7;
    // ----------------------------------------------------------------
    // main counter sources
    // ----------------------------------------------------------------
    localparam logic [1:0]  MODE_FREE   = 2'h0;
    localparam logic [1:0]  MODE_EVENT  = 2'h1;
    localparam logic [1:0]  MODE_PWM    = 2'h2;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_PERIOD  = 16'hffff;
    localparam logic [7:0]  RST_C_PER   = 8'hff;
    // ----------------------------------------------------------------
    // capture input timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          MIN_PULSE_TENTHS = 15;
    localparam int          MIN_PULSE_CYC    = (MIN_PULSE_TENTHS + 9) / 10;
endpackage

/* rtl/ir_timer_pair.sv */
// pwm timer pair: 16-bit five-channel timer, 8-bit companion, ir gating
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ir_timer_pair (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // pins
    input  wire logic [4:0]  capture_in,
    input  wire logic        count_in,
    output logic [4:0]       pwm_out,
    output logic             companion_out,
    output logic             ir_out,
    // interrupt
    output logic             irq
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [3:0]  ctrl;
    logic [15:0] presc;
    logic [15:0] presc_cnt;
    logic [15:0] period;
    logic [15:0] count;
    logic [4:0]  ch_capture;
    logic [15:0] cmp [5];
    logic [15:0] c_ctrl;
    logic [7:0]  c_presc_cnt;
    logic [7:0]  c_period;
    logic [7:0]  c_cmp;
    logic [7:0]  c_count;
    logic [6:0]  status;
    logic [6:0]  mask;
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic [5:0]  sync_prev;

    logic [3:0]  next_ctrl;
    logic [15:0] next_presc;
    logic [15:0] next_presc_cnt;
    logic [15:0] next_period;
    logic [15:0] next_count;
    logic [4:0]  next_ch_capture;
    logic [15:0] next_cmp [5];
    logic [15:0] next_c_ctrl;
    logic [7:0]  next_c_presc_cnt;
    logic [7:0]  next_c_period;
    logic [7:0]  next_c_cmp;
    logic [7:0]  next_c_count;
    logic [6:0]  next_status;
    logic [6:0]  next_mask;
    logic        next_pready;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic [4:0]  next_pwm;
    logic        next_c_out;
    logic        next_ir;
    logic        next_irq;

    logic        wr;
    logic        rd;
    logic        tick;
    logic        c_tick;
    logic        c_wrap;
    logic        advance;
    logic        wrap;
    logic [5:0]  rise;
    logic [6:0]  events;
    logic [2:0]  ch_idx;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic below(input logic [15:0] cnt, input logic [15:0] thr);
        below = cnt < thr;
    endfunction

    function automatic logic in_cmp_range(input logic [7:0] a);
        in_cmp_range = (a >= ir_timer_pkg::OFS_CMP0) && (a <= ir_timer_pkg::OFS_CMP4);
    endfunction

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl        = ctrl;
        next_presc       = presc;
        next_period      = period;
        next_ch_capture  = ch_capture;
        for (int i = 0; i < 5; i++) begin
            next_cmp[i] = cmp[i];
        end
        next_c_ctrl      = c_ctrl;
        next_c_period    = c_period;
        next_c_cmp       = c_cmp;
        next_mask        = mask;
        next_prdata      = prdata;
        next_pslverr     = 1'b0;
        ch_idx           = 3'((paddr - ir_timer_pkg::OFS_CMP0) >> 2);

        // bus handshake: one wait state
        next_pready      = psel & penable & ~pready;
        wr               = psel & penable & pready & pwrite;
        rd               = psel & penable & ~pready & ~pwrite;

        // synchronised pins, rising edges
        rise             = sync2 & ~sync_prev;

        // companion timer
        c_tick           = 1'b0;
        next_c_presc_cnt = c_presc_cnt;
        next_c_count     = c_count;
        if (c_ctrl[ir_timer_pkg::CCTRL_RUN]) begin
            if (c_presc_cnt >= c_ctrl[15:8]) begin
                next_c_presc_cnt = 8'h00;
                c_tick           = 1'b1;
            end else begin
                next_c_presc_cnt = c_presc_cnt + 8'h01;
            end
        end
        c_wrap = c_tick & (c_count >= c_period);
        if (c_tick) begin
            next_c_count = c_wrap ? 8'h00 : c_count + 8'h01;
        end
        next_c_out = below({8'h00, next_c_count}, {8'h00, c_cmp});

        // main timer prescaler and source
        tick           = 1'b0;
        next_presc_cnt = presc_cnt;
        if (ctrl[ir_timer_pkg::CTRL_RUN]) begin
            if (presc_cnt >= presc) begin
                next_presc_cnt = 16'h0000;
                tick           = 1'b1;
            end else begin
                next_presc_cnt = presc_cnt + 16'h0001;
            end
        end
        if (ctrl[ir_timer_pkg::CTRL_IR]) begin
            advance = ctrl[ir_timer_pkg::CTRL_RUN] & c_wrap;
        end else if (ctrl[2:1] == ir_timer_pkg::MODE_EVENT) begin
            advance = ctrl[ir_timer_pkg::CTRL_RUN] & rise[5];
        end else begin
            advance = tick;
        end
        wrap       = advance & (count >= period);
        next_count = count;
        if (advance) begin
            next_count = wrap ? 16'h0000 : count + 16'h0001;
        end

        // channel compare outputs and match events
        events = {c_wrap, wrap, 5'h00};
        for (int i = 0; i < 5; i++) begin
            next_pwm[i] = ~ch_capture[i] & below(next_count, cmp[i]);
            if (!ch_capture[i] && advance && next_count == cmp[i]) begin
                events[i] = 1'b1;
            end
        end
        next_ir = next_pwm[0] & next_c_out;

        // register reads
        if (rd) begin
            next_pslverr = 1'b0;
            case (paddr)
                ir_timer_pkg::OFS_CTRL:    next_prdata = {28'h0000000, ctrl};
                ir_timer_pkg::OFS_PRESC:   next_prdata = {16'h0000, presc};
                ir_timer_pkg::OFS_PERIOD:  next_prdata = {16'h0000, period};
                ir_timer_pkg::OFS_COUNT:   next_prdata = {16'h0000, count};
                ir_timer_pkg::OFS_CHMODE:  next_prdata = {27'h0000000, ch_capture};
                ir_timer_pkg::OFS_C_CTRL:  next_prdata = {16'h0000, c_ctrl};
                ir_timer_pkg::OFS_C_PER:   next_prdata = {24'h000000, c_period};
                ir_timer_pkg::OFS_C_CMP:   next_prdata = {24'h000000, c_cmp};
                ir_timer_pkg::OFS_C_COUNT: next_prdata = {24'h000000, c_count};
                ir_timer_pkg::OFS_STATUS:  next_prdata = {25'h0000000, status};
                ir_timer_pkg::OFS_MASK:    next_prdata = {25'h0000000, mask};
                default: begin
                    if (in_cmp_range(paddr) && paddr[1:0] == 2'h0) begin
                        next_prdata = {16'h0000, cmp[ch_idx]};
                    end else begin
                        next_prdata  = 32'h00000000;
                        next_pslverr = 1'b1;
                    end
                end
            endcase
        end else if (psel & penable & ~pready & pwrite) begin
            next_prdata  = 32'h00000000;
            next_pslverr = !((paddr <= ir_timer_pkg::OFS_MASK) && paddr[1:0] == 2'h0);
        end

        // register writes, taken on the completing edge
        if (wr) begin
            case (paddr)
                ir_timer_pkg::OFS_CTRL:   next_ctrl       = pwdata[3:0];
                ir_timer_pkg::OFS_PRESC:  next_presc      = pwdata[15:0];
                ir_timer_pkg::OFS_PERIOD: next_period     = pwdata[15:0];
                ir_timer_pkg::OFS_CHMODE: next_ch_capture = pwdata[4:0];
                ir_timer_pkg::OFS_C_CTRL: next_c_ctrl     = pwdata[15:0];
                ir_timer_pkg::OFS_C_PER:  next_c_period   = pwdata[7:0];
                ir_timer_pkg::OFS_C_CMP:  next_c_cmp      = pwdata[7:0];
                ir_timer_pkg::OFS_MASK:   next_mask       = pwdata[6:0];
                default: begin
                    if (in_cmp_range(paddr) && paddr[1:0] == 2'h0) begin
                        next_cmp[ch_idx] = pwdata[15:0];
                    end
                end
            endcase
        end

        // capture wins over a software write in the same cycle
        for (int i = 0; i < 5; i++) begin
            if (ch_capture[i] && rise[i]) begin
                next_cmp[i] = count;
                events[i]   = 1'b1;
            end
        end

        // sticky status, set wins over write-one-to-clear
        next_status = status;
        if (wr && paddr == ir_timer_pkg::OFS_STATUS) begin
            next_status = status & ~pwdata[6:0];
        end
        next_status = next_status | events;
        next_irq    = |(next_status & next_mask);
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl          <= 4'h0;
            presc         <= 16'h0000;
            presc_cnt     <= 16'h0000;
            period        <= ir_timer_pkg::RST_PERIOD;
            count         <= 16'h0000;
            ch_capture    <= 5'h00;
            for (int i = 0; i < 5; i++) begin
                cmp[i] <= 16'h0000;
            end
            c_ctrl        <= 16'h0000;
            c_presc_cnt   <= 8'h00;
            c_period      <= ir_timer_pkg::RST_C_PER;
            c_cmp         <= 8'h00;
            c_count       <= 8'h00;
            status        <= 7'h00;
            mask          <= 7'h00;
            sync1         <= 6'h00;
            sync2         <= 6'h00;
            sync_prev     <= 6'h00;
            pready        <= 1'b0;
            prdata        <= 32'h00000000;
            pslverr       <= 1'b0;
            pwm_out       <= 5'h00;
            companion_out <= 1'b0;
            ir_out        <= 1'b0;
            irq           <= 1'b0;
        end else begin
            ctrl          <= next_ctrl;
            presc         <= next_presc;
            presc_cnt     <= next_presc_cnt;
            period        <= next_period;
            count         <= next_count;
            ch_capture    <= next_ch_capture;
            for (int i = 0; i < 5; i++) begin
                cmp[i] <= next_cmp[i];
            end
            c_ctrl        <= next_c_ctrl;
            c_presc_cnt   <= next_c_presc_cnt;
            c_period      <= next_c_period;
            c_cmp         <= next_c_cmp;
            c_count       <= next_c_count;
            status        <= next_status;
            mask          <= next_mask;
            sync1         <= {count_in, capture_in};
            sync2         <= sync1;
            sync_prev     <= sync2;
            pready        <= next_pready;
            prdata        <= next_prdata;
            pslverr       <= next_pslverr;
            pwm_out       <= next_pwm;
            companion_out <= next_c_out;
            ir_out        <= next_ir;
            irq           <= next_irq;
        end
    end
endmodule
`default_nettype wire

/* sim/ir_timer_sva.sv */
// port checker for the timer pair
`timescale 1ns/1ns
`default_nettype none
module ir_timer_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // pins
    input wire logic [4:0]  pwm_out,
    input wire logic        companion_out,
    input wire logic        ir_out,
    input wire logic        irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("wait state");
    a_ready_cause: assert property (pready |-> psel && penable) else $error("pready unasked");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused data");
    a_data_hold: assert property (!pready |-> $stable(prdata)) else $error("prdata moved");
    a_ir_gate: assert property (ir_out == (pwm_out[0] & companion_out)) else $error("ir gate");
    a_reset_quiet: assert property (!$past(arst_n) |-> pwm_out == 5'h0 && !ir_out && !irq) else $error("rst");
    c_refused: cover property (pready && pslverr);
    c_ir: cover property ($rose(ir_out));
    c_irq: cover property ($rose(irq));
endmodule
bind ir_timer_pair ir_timer_sva chk_i (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_out(pwm_out),
    .companion_out(companion_out), .ir_out(ir_out), .irq(irq));
`default_nettype wire

/* sim/pin_model.sv */
// pin model making capture and count pulses
`timescale 1ns/1ns
`default_nettype none
module pin_model (
    // clock
    input wire logic       clk,
    // pulse requests
    input wire logic [4:0] cap_req,
    input wire logic       cnt_req,
    // pins
    output logic [4:0]     capture_in,
    output logic           count_in
);
    logic [2:0] age = 3'h0;
    initial capture_in = 5'h0;
    initial count_in = 1'b0;
    // high two clocks, then low at least three clocks
    always @(posedge clk) begin
        if (age == 3'h0 && (cap_req != 5'h0 || cnt_req)) begin
            capture_in <= cap_req;
            count_in <= cnt_req;
            age <= 3'h4;
        end else if (age != 3'h0) begin
            age <= age - 3'h1;
            if (age == 3'h3) begin
                capture_in <= 5'h0;
                count_in <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tb.sv */
// random and corner tests of the timer pair
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cnt_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [4:0] cap_req = 5'h0, capture_in, pwm_out;
    logic pready, pslverr, count_in, companion_out, ir_out, irq;
    int err_total = 0, checks = 0, p, c, s, cp, cc, cs, n;
    always #50 clk = ~clk;
    ir_timer_pair uut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .capture_in(capture_in), .count_in(count_in), .pwm_out(pwm_out),
        .companion_out(companion_out), .ir_out(ir_out), .irq(irq));
    pin_model pins (.clk(clk), .cap_req(cap_req), .cnt_req(cnt_req), .capture_in(capture_in),
        .count_in(count_in));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input int v);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, 32'(v), q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk("prdata", q, x);
        chk("pslverr", {31'h0, e}, {31'h0, xe});
    endtask
    task automatic pulse(input logic [4:0] cap, input logic cnt);
        @(posedge clk);
        cap_req <= cap;
        cnt_req <= cnt;
        @(posedge clk);
        cap_req <= 5'h0;
        cnt_req <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
    endtask
    task automatic meas(input int sel, input int len, input int exp);
        int ones;
        ones = 0;
        repeat (len) begin
            @(posedge clk);
            if ((sel == 0 ? pwm_out[0] : sel == 1 ? companion_out : sel == 2 ? ir_out : pwm_out[4]) === 1'b1) ones++;
        end
        chk("high cycles", 32'(ones), 32'(exp));
    endtask
    // high cycles in one full period of a compare output
    function automatic int duty(int cmp, int top, int div);
        return (cmp > top ? top + 1 : cmp) * div;
    endfunction
    initial begin
        #3ms;
        err_total++;
        give_verdict();
    end
    initial begin
        void'($urandom(69));
        do_reset();
        rd(8'h08, 32'hffff, 1'b0);
        rd(8'h2c, 32'hff, 1'b0);
        rd(8'h00, 32'h0, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        rd(8'h06, 32'h0, 1'b1);
        for (int i = 0; i < 5; i++) begin
            d = $urandom;
            wr(8'h14 + 8'(4 * i), d);
            rd(8'h14 + 8'(4 * i), {16'h0, d[15:0]}, 1'b0);
        end
        d = $urandom;
        wr(8'h30, d);
        rd(8'h30, {24'h0, d[7:0]}, 1'b0);
        $display("test registers done");
        do_reset();
        n = 1 + $urandom % 5;
        wr(8'h00, 3);
        repeat (n) pulse(5'h0, 1'b1);
        wr(8'h0c, 255);
        rd(8'h0c, 32'(n), 1'b0);
        wr(8'h10, 2);
        wr(8'h3c, 2);
        pulse(5'h2, 1'b0);
        chk("irq", {31'h0, irq}, 32'h1);
        chk("pwm_out", {27'h0, pwm_out[4:1], 1'b0}, 32'h0);
        rd(8'h38, 32'h2, 1'b0);
        rd(8'h18, 32'(n), 1'b0);
        wr(8'h38, 2);
        wr(8'h3c, 0);
        pulse(5'h2, 1'b0);
        chk("irq", {31'h0, irq}, 32'h0);
        rd(8'h38, 32'h2, 1'b0);
        $display("test event and capture done");
        for (int m = 0; m < 2; m++) begin
            do_reset();
            p = 2 + $urandom % 3;
            c = $urandom % (p + 2);
            s = $urandom % 3;
            wr(8'h04, s);
            wr(8'h08, p);
            wr(8'h14, c);
            cc = $urandom % (p + 2);
            wr(8'h24, cc);
            wr(8'h00, 1 + 4 * m);
            repeat ((p + 1) * (s + 1) + 4) @(posedge clk);
            meas(0, (p + 1) * (s + 1), duty(c, p, s + 1));
            meas(3, (p + 1) * (s + 1), duty(cc, p, s + 1));
            rd(8'h38, 32'h2e | 32'(c <= p) | (32'(cc <= p) << 4), 1'b0);
        end
        $display("test free and pwm done");
        do_reset();
        cp = 1 + $urandom % 3;
        cc = $urandom % (cp + 2);
        cs = $urandom % 2;
        p = 1 + $urandom % 3;
        c = $urandom % (p + 2);
        wr(8'h2c, cp);
        wr(8'h30, cc);
        wr(8'h08, p);
        wr(8'h14, c);
        wr(8'h28, 1 + 256 * cs);
        wr(8'h00, 9);
        n = (p + 1) * (cp + 1) * (cs + 1);
        repeat (n + 8) @(posedge clk);
        meas(1, (cp + 1) * (cs + 1), duty(cc, cp, cs + 1));
        meas(0, n, duty(c, p, (cp + 1) * (cs + 1)));
        meas(2, n, duty(c, p, duty(cc, cp, cs + 1)));
        rd(8'h38, 32'h7e | 32'(c <= p), 1'b0);
        $display("test ir carrier done");
        give_verdict();
    end
endmodule
`default_nettype wire
